// ==== vomc_top.sv ====
// Function
// - Mode 111 means ED-only input at 54 MHz
// - Port swap option applies to SD only
// - Black bar needs its test-pattern enable too
// - Manual matrix bit selects programmed coefficients
// - Sync on RGB, and RGB/YPrPb select
// - SD sync enable drives SD syncs out when ED/HD sync enable is clear
// - ED/HD sync enable drives ED/HD syncs out
`timescale 1ns/1ps
`include "vomc_params.svh"
`default_nettype none

module vomc_top
    import vomc_pkg::*;
#(
    parameter int COEF_W = 10
) (
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    // Register port from serial control decoder
    input  wire logic              REG_WR_I,
    input  wire logic [7:0]        REG_ADDR_I,
    input  wire logic [7:0]        REG_WDATA_I,
    output logic      [7:0]        REG_RDATA_O,
    // Test-pattern enables from other registers
    input  wire logic              ED_TP_EN_I,
    input  wire logic              SD_TP_EN_I,
    // Syncs from the timing generators
    input  wire logic              SD_HSYNC_I,
    input  wire logic              SD_VSYNC_I,
    input  wire logic              ED_HSYNC_I,
    input  wire logic              ED_VSYNC_I,
    // Input path control
    output logic                   SD_PATH_EN_O,
    output logic                   ED_PATH_EN_O,
    output logic                   ED_DDR_O,
    output logic                   ED_54M_ONLY_O,
    output logic                   PORT_SWAP_O,
    output logic      [1:0]        DDR_EDGE_O,
    // Output mode control
    output logic                   BLACK_BAR_ED_O,
    output logic                   BLACK_BAR_SD_O,
    output logic                   CSC_MANUAL_O,
    output logic                   SYNC_ON_RGB_O,
    output logic                   YPRPB_SEL_O,
    output logic                   S_HSYNC_O,
    output logic                   S_VSYNC_O,
    // Conversion coefficients
    output logic [COEF_W-1:0]      GREEN_LUMA_COEF_O,
    output logic [COEF_W-1:0]      GREEN_BLUE_DIFF_COEF_O,
    output logic [COEF_W-1:0]      GREEN_RED_DIFF_COEF_O,
    output logic [COEF_W-1:0]      BLUE_FROM_DIFF_COEF_O,
    output logic [COEF_W-1:0]      RED_FROM_DIFF_COEF_O
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]          mode_sel_reg;
    logic [7:0]          out_mode_reg;
    logic [7:0]          lob_a_reg;
    logic [7:0]          lob_b_reg;
    logic [7:0]          gy_hi_reg;
    logic [7:0]          gu_hi_reg;
    logic [7:0]          gv_hi_reg;
    logic [7:0]          bu_hi_reg;
    logic [7:0]          rv_hi_reg;
    logic [7:0]          rdata_next;
    vomc_in_mode_type    in_mode;
    logic                sd_active;
    logic                ed_active;
    logic                sd_sync_en;
    logic                ed_sync_en;
    logic [5*COEF_W-1:0] coef_all;
    // Address hits
    wire hit_msel = (REG_ADDR_I == `VOMC_OFS_MODE_SELECT);
    wire hit_omod = (REG_ADDR_I == `VOMC_OFS_OUT_MODE);
    wire hit_loa  = (REG_ADDR_I == `VOMC_OFS_LOW_BITS_A);
    wire hit_lob  = (REG_ADDR_I == `VOMC_OFS_LOW_BITS_B);
    wire hit_gy   = (REG_ADDR_I == `VOMC_OFS_GREEN_LUMA);
    wire hit_gu   = (REG_ADDR_I == `VOMC_OFS_GREEN_BLUE_DIFF);
    wire hit_gv   = (REG_ADDR_I == `VOMC_OFS_GREEN_RED_DIFF);
    wire hit_bu   = (REG_ADDR_I == `VOMC_OFS_BLUE_FROM_DIFF);
    wire hit_rv   = (REG_ADDR_I == `VOMC_OFS_RED_FROM_DIFF);
    // Register writes; reserved bits masked so they read back zero
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mode_sel_reg <= `VOMC_RST_MODE_SELECT;
            out_mode_reg <= `VOMC_RST_OUT_MODE;
            lob_a_reg    <= `VOMC_RST_LOW_BITS_A;
            lob_b_reg    <= `VOMC_RST_LOW_BITS_B;
            gy_hi_reg    <= `VOMC_RST_GREEN_LUMA;
            gu_hi_reg    <= `VOMC_RST_GREEN_BLUE_DIFF;
            gv_hi_reg    <= `VOMC_RST_GREEN_RED_DIFF;
            bu_hi_reg    <= `VOMC_RST_BLUE_FROM_DIFF;
            rv_hi_reg    <= `VOMC_RST_RED_FROM_DIFF;
        end
        else if (REG_WR_I)
        begin
            if (hit_msel)
                mode_sel_reg <= REG_WDATA_I & `VOMC_WMASK_MODE_SELECT;
            if (hit_omod)
                out_mode_reg <= REG_WDATA_I & `VOMC_WMASK_OUT_MODE;
            if (hit_loa)
                lob_a_reg <= REG_WDATA_I;
            if (hit_lob)
                lob_b_reg <= REG_WDATA_I;
            if (hit_gy)
                gy_hi_reg <= REG_WDATA_I;
            if (hit_gu)
                gu_hi_reg <= REG_WDATA_I;
            if (hit_gv)
                gv_hi_reg <= REG_WDATA_I;
            if (hit_bu)
                bu_hi_reg <= REG_WDATA_I;
            if (hit_rv)
                rv_hi_reg <= REG_WDATA_I;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped subaddresses read as zero
    assign rdata_next = hit_msel ? mode_sel_reg :
                        hit_omod ? out_mode_reg :
                        hit_loa  ? lob_a_reg    :
                        hit_lob  ? lob_b_reg    :
                        hit_gy   ? gy_hi_reg    :
                        hit_gu   ? gu_hi_reg    :
                        hit_gv   ? gv_hi_reg    :
                        hit_bu   ? bu_hi_reg    :
                        hit_rv   ? rv_hi_reg    : 8'h00;
    // ****************************************************************
    // Mode decode
    // ****************************************************************
    // Input mode field to active input paths
    assign in_mode   = vomc_decode_mode(
        mode_sel_reg[`VOMC_BIT_IN_MODE_HI:`VOMC_BIT_IN_MODE_LO]);
    assign sd_active = (in_mode == VOMC_IN_SD_ONLY) ||
                       (in_mode == VOMC_IN_SD_ED_SDR) ||
                       (in_mode == VOMC_IN_SD_ED_DDR);
    assign ed_active = (in_mode != VOMC_IN_SD_ONLY) &&
                       (in_mode != VOMC_IN_RESERVED);
    assign sd_sync_en = out_mode_reg[`VOMC_BIT_SD_SYNC_EN];
    assign ed_sync_en = out_mode_reg[`VOMC_BIT_ED_SYNC_EN];
    // Coefficient joining; slice order is red, blue, gv, gu, gy
    vomc_coef_join #(
        .HI_W (COEF_W - 2),
        .LO_W (2)
    ) u_join [4:0] (
        .hi_i   ({rv_hi_reg, bu_hi_reg, gv_hi_reg, gu_hi_reg, gy_hi_reg}),
        .lo_i   ({lob_b_reg[`VOMC_LOB_B_RED_FROM_DIFF +: 2],
                  lob_b_reg[`VOMC_LOB_B_BLUE_FROM_DIFF +: 2],
                  lob_b_reg[`VOMC_LOB_B_GREEN_RED_DIFF +: 2],
                  lob_b_reg[`VOMC_LOB_B_GREEN_BLUE_DIFF +: 2],
                  lob_a_reg[`VOMC_LOB_A_GREEN_LUMA +: 2]}),
        .coef_o (coef_all)
    );
    // ****************************************************************
    // Output flops
    // ****************************************************************
    // All outputs registered so downstream sees glitch-free levels
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            REG_RDATA_O            <= 8'h00;
            SD_PATH_EN_O           <= 1'b0;
            ED_PATH_EN_O           <= 1'b0;
            ED_DDR_O               <= 1'b0;
            ED_54M_ONLY_O          <= 1'b0;
            PORT_SWAP_O            <= 1'b0;
            DDR_EDGE_O             <= 2'h0;
            BLACK_BAR_ED_O         <= 1'b0;
            BLACK_BAR_SD_O         <= 1'b0;
            CSC_MANUAL_O           <= 1'b0;
            SYNC_ON_RGB_O          <= 1'b0;
            YPRPB_SEL_O            <= 1'b0;
            S_HSYNC_O              <= 1'b0;
            S_VSYNC_O              <= 1'b0;
            GREEN_LUMA_COEF_O      <= '0;
            GREEN_BLUE_DIFF_COEF_O <= '0;
            GREEN_RED_DIFF_COEF_O  <= '0;
            BLUE_FROM_DIFF_COEF_O  <= '0;
            RED_FROM_DIFF_COEF_O   <= '0;
        end
        else
        begin
            REG_RDATA_O   <= rdata_next;
            SD_PATH_EN_O  <= sd_active;
            ED_PATH_EN_O  <= ed_active;
            ED_DDR_O      <= (in_mode == VOMC_IN_ED_DDR) ||
                             (in_mode == VOMC_IN_SD_ED_DDR);
            ED_54M_ONLY_O <= (in_mode == VOMC_IN_ED_54M);
            // Swap is meaningless without an SD path
            PORT_SWAP_O   <= mode_sel_reg[`VOMC_BIT_PORT_SWAP] &&
                             sd_active;
            DDR_EDGE_O    <= mode_sel_reg[`VOMC_BIT_DDR_EDGE_HI:
                                          `VOMC_BIT_DDR_EDGE_LO];
            BLACK_BAR_ED_O <= out_mode_reg[`VOMC_BIT_BLACK_BAR] &&
                              ED_TP_EN_I;
            BLACK_BAR_SD_O <= out_mode_reg[`VOMC_BIT_BLACK_BAR] &&
                              SD_TP_EN_I;
            CSC_MANUAL_O  <= out_mode_reg[`VOMC_BIT_CSC_MANUAL];
            SYNC_ON_RGB_O <= out_mode_reg[`VOMC_BIT_SYNC_ON_RGB];
            YPRPB_SEL_O   <= out_mode_reg[`VOMC_BIT_YPRPB_SEL];
            // Shared pins: ED/HD wins if both enables are set
            S_HSYNC_O <= ed_sync_en ? ED_HSYNC_I :
                         (sd_sync_en && SD_HSYNC_I);
            S_VSYNC_O <= ed_sync_en ? ED_VSYNC_I :
                         (sd_sync_en && SD_VSYNC_I);
            GREEN_LUMA_COEF_O      <= coef_all[0*COEF_W +: COEF_W];
            GREEN_BLUE_DIFF_COEF_O <= coef_all[1*COEF_W +: COEF_W];
            GREEN_RED_DIFF_COEF_O  <= coef_all[2*COEF_W +: COEF_W];
            BLUE_FROM_DIFF_COEF_O  <= coef_all[3*COEF_W +: COEF_W];
            RED_FROM_DIFF_COEF_O   <= coef_all[4*COEF_W +: COEF_W];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_rsvd_zero;
        REG_WR_I && hit_omod |=> ##1 (REG_RDATA_O[1:0] == 2'h0) || !$past(hit_omod);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("output mode reserved bits not zero");
    property p_ed_54m;
        REG_WR_I && hit_msel && (REG_WDATA_I[6:4] == 3'h7)
            |=> ##1 ED_54M_ONLY_O && !SD_PATH_EN_O && ED_PATH_EN_O;
    endproperty
    a_ed_54m: assert property (p_ed_54m)
        else $error("mode 111 not decoded as ED only");
    property p_swap_sd;
        PORT_SWAP_O |-> SD_PATH_EN_O;
    endproperty
    a_swap_sd: assert property (p_swap_sd)
        else $error("port swap active without SD path");
    property p_bar_on;
        out_mode_reg[2] && ED_TP_EN_I && !SD_TP_EN_I
            |=> BLACK_BAR_ED_O && !BLACK_BAR_SD_O;
    endproperty
    a_bar_on: assert property (p_bar_on)
        else $error("black bar gating wrong");
    property p_bar_off;
        !out_mode_reg[2] |=> !BLACK_BAR_ED_O && !BLACK_BAR_SD_O;
    endproperty
    a_bar_off: assert property (p_bar_off)
        else $error("black bar on while disabled");
    property p_csc_man;
        REG_WR_I && hit_omod |=> ##1 CSC_MANUAL_O == $past(REG_WDATA_I[3], 2);
    endproperty
    a_csc_man: assert property (p_csc_man)
        else $error("manual matrix bit not applied");
    property p_rgb_sync;
        REG_WR_I && hit_omod |=> ##1
            (SYNC_ON_RGB_O == $past(REG_WDATA_I[4], 2)) &&
            (YPRPB_SEL_O == $past(REG_WDATA_I[5], 2));
    endproperty
    a_rgb_sync: assert property (p_rgb_sync)
        else $error("sync on RGB or component select wrong");
    property p_sd_sync;
        sd_sync_en && !ed_sync_en |=> (S_HSYNC_O == $past(SD_HSYNC_I)) &&
                                      (S_VSYNC_O == $past(SD_VSYNC_I));
    endproperty
    a_sd_sync: assert property (p_sd_sync)
        else $error("SD sync not on sync pins");
    property p_ed_sync;
        ed_sync_en |=> (S_HSYNC_O == $past(ED_HSYNC_I)) &&
                       (S_VSYNC_O == $past(ED_VSYNC_I));
    endproperty
    a_ed_sync: assert property (p_ed_sync)
        else $error("ED/HD sync not on sync pins");
    property p_no_sync;
        !sd_sync_en && !ed_sync_en |=> !S_HSYNC_O && !S_VSYNC_O;
    endproperty
    a_no_sync: assert property (p_no_sync)
        else $error("sync output while disabled");
    property p_coef_join;
        REG_WR_I && hit_rv && !$past(REG_WR_I && hit_lob)
            |=> ##1 RED_FROM_DIFF_COEF_O[9:2] == $past(REG_WDATA_I, 2);
    endproperty
    a_coef_join: assert property (p_coef_join)
        else $error("coefficient upper bits wrong");
    c_ed_54m:   cover property (ED_54M_ONLY_O);
    c_ed_sync:  cover property (ed_sync_en && sd_sync_en);
    c_bar_sd:   cover property (BLACK_BAR_SD_O);
    c_csc_man:  cover property (CSC_MANUAL_O && PORT_SWAP_O);

endmodule // vomc_top

`default_nettype wire

// ==== vomc_params.svh ====
`ifndef VOMC_PARAMS_SVH
`define VOMC_PARAMS_SVH

// ****************************************************************
// Register offsets on the serial control port
// ****************************************************************
`define VOMC_OFS_MODE_SELECT      8'h01
`define VOMC_OFS_OUT_MODE         8'h02
`define VOMC_OFS_LOW_BITS_A       8'h03
`define VOMC_OFS_LOW_BITS_B       8'h04
`define VOMC_OFS_GREEN_LUMA       8'h05
`define VOMC_OFS_GREEN_BLUE_DIFF  8'h06
`define VOMC_OFS_GREEN_RED_DIFF   8'h07
`define VOMC_OFS_BLUE_FROM_DIFF   8'h08
`define VOMC_OFS_RED_FROM_DIFF    8'h09

// ****************************************************************
// Reset values
// ****************************************************************
`define VOMC_RST_MODE_SELECT      8'h00
`define VOMC_RST_OUT_MODE         8'h20
`define VOMC_RST_LOW_BITS_A       8'h03
`define VOMC_RST_LOW_BITS_B       8'hf0
`define VOMC_RST_GREEN_LUMA       8'h4e
`define VOMC_RST_GREEN_BLUE_DIFF  8'h0e
`define VOMC_RST_GREEN_RED_DIFF   8'h24
`define VOMC_RST_BLUE_FROM_DIFF   8'h92
`define VOMC_RST_RED_FROM_DIFF    8'h7c

// ****************************************************************
// Writable bit masks (reserved bits stay zero)
// ****************************************************************
`define VOMC_WMASK_MODE_SELECT    8'hf6
`define VOMC_WMASK_OUT_MODE       8'hfc

// ****************************************************************
// Field positions
// ****************************************************************
`define VOMC_BIT_DDR_EDGE_LO      1
`define VOMC_BIT_DDR_EDGE_HI      2
`define VOMC_BIT_IN_MODE_LO       4
`define VOMC_BIT_IN_MODE_HI       6
`define VOMC_BIT_PORT_SWAP        7
`define VOMC_BIT_BLACK_BAR        2
`define VOMC_BIT_CSC_MANUAL       3
`define VOMC_BIT_SYNC_ON_RGB      4
`define VOMC_BIT_YPRPB_SEL        5
`define VOMC_BIT_SD_SYNC_EN       6
`define VOMC_BIT_ED_SYNC_EN       7
`define VOMC_LOB_A_GREEN_LUMA     0
`define VOMC_LOB_B_RED_FROM_DIFF  0
`define VOMC_LOB_B_BLUE_FROM_DIFF 2
`define VOMC_LOB_B_GREEN_RED_DIFF 4
`define VOMC_LOB_B_GREEN_BLUE_DIFF 6

`endif

// ==== vomc_pkg.sv ====
`default_nettype none

package vomc_pkg;

    // Decoded input-mode field
    typedef enum {
        VOMC_IN_SD_ONLY,
        VOMC_IN_ED_SDR,
        VOMC_IN_ED_DDR,
        VOMC_IN_SD_ED_SDR,
        VOMC_IN_SD_ED_DDR,
        VOMC_IN_ED_54M,
        VOMC_IN_RESERVED
    } vomc_in_mode_type;

    function automatic vomc_in_mode_type vomc_decode_mode(
        input logic [2:0] field
    );
        case (field)
            3'h0:    return VOMC_IN_SD_ONLY;
            3'h1:    return VOMC_IN_ED_SDR;
            3'h2:    return VOMC_IN_ED_DDR;
            3'h3:    return VOMC_IN_SD_ED_SDR;
            3'h4:    return VOMC_IN_SD_ED_DDR;
            3'h7:    return VOMC_IN_ED_54M;
            default: return VOMC_IN_RESERVED;
        endcase
    endfunction

endpackage

`default_nettype wire

// ==== vomc_coef_join.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Joins upper and lower coefficient bits into one coefficient
// ****************************************************************
module vomc_coef_join #(
    parameter int HI_W = 8,
    parameter int LO_W = 2
) (
    // Coefficient parts
    input  wire logic [HI_W-1:0]      hi_i,
    input  wire logic [LO_W-1:0]      lo_i,
    // Joined coefficient
    output logic [HI_W+LO_W-1:0]      coef_o
);

    // Upper bits from own register, low bits from shared one
    assign coef_o = {hi_i, lo_i};

endmodule // vomc_coef_join

`default_nettype wire

// ==== vomc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host on the serial control port, seen at the register port
// ****************************************************************
module vomc_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register port
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i
);
    // Quiet port at time zero
    initial
    begin
        wr_o    = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end

    // Strobe left high so that writes may run back to back
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= (a == 8'h02) ? (d & 8'hfc) : d;
        @(posedge clk_i);
    endtask

    // Data lines toggle during a read, never hold the last byte
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= a;
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
        @(negedge clk_i);
        d = rdata_i;
    endtask

    // Drop the strobe; address and data keep their last values
    task automatic idle;
        @(negedge clk_i);
        wr_o <= 1'b0;
    endtask
endmodule // vomc_host_model

`default_nettype wire

// ==== tb_video_output_mode_csc_config.sv ====
`timescale 1ns/1ps
`include "vomc_params.svh"
`default_nettype none

module tb_video_output_mode_csc_config;
    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  m01;
        logic [7:0]  m02;
        logic [1:0]  tp;
        logic [3:0]  syn;
        logic [13:0] exp;
    } vomc_row_type;

    logic        clk;
    logic        rst_n;
    logic        ed_tp, sd_tp, sd_h, sd_v, ed_h, ed_v;
    wire         wr;
    wire  [7:0]  addr, wdata, rdata;
    wire         sdp, edp, ddr, m54, swp, bbe, bbs, csc, sor, ypr, sh, sv;
    wire  [1:0]  edge_sel;
    wire  [9:0]  gl, gu, gv, bu, rv;
    wire  [13:0] flags;
    logic [7:0]  rd;
    int          n_errors;
    int          samples_checked;
    logic [7:0]  rst_val [9] = '{`VOMC_RST_MODE_SELECT, `VOMC_RST_OUT_MODE,
        `VOMC_RST_LOW_BITS_A, `VOMC_RST_LOW_BITS_B, `VOMC_RST_GREEN_LUMA,
        `VOMC_RST_GREEN_BLUE_DIFF, `VOMC_RST_GREEN_RED_DIFF,
        `VOMC_RST_BLUE_FROM_DIFF, `VOMC_RST_RED_FROM_DIFF};
    // Flag order: sd ed ddr 54m swap edge[1:0] bb_ed bb_sd csc sor ypr h v
    vomc_row_type rows [7] = '{
        '{8'h80, 8'h04, 2'b11, 4'hf, 14'b10001001100000},
        '{8'hf6, 8'h88, 2'b01, 4'h6, 14'b01010110010010},
        '{8'h40, 8'h74, 2'b10, 4'h9, 14'b11100001001110},
        '{8'ha0, 8'hc0, 2'b11, 4'h9, 14'b01100000000001},
        '{8'hb0, 8'h4c, 2'b01, 4'h6, 14'b11001000110001},
        '{8'h50, 8'h3c, 2'b00, 4'hf, 14'b00000000011100},
        '{8'h12, 8'h00, 2'b00, 4'h0, 14'b01000010000000}};

    assign flags = {sdp, edp, ddr, m54, swp, edge_sel, bbe, bbs, csc, sor,
                    ypr, sh, sv};

    // ****************************************************************
    // Design and host
    // ****************************************************************
    vomc_top dut (
        .CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ED_TP_EN_I(ed_tp),
        .SD_TP_EN_I(sd_tp), .SD_HSYNC_I(sd_h), .SD_VSYNC_I(sd_v),
        .ED_HSYNC_I(ed_h), .ED_VSYNC_I(ed_v), .SD_PATH_EN_O(sdp),
        .ED_PATH_EN_O(edp), .ED_DDR_O(ddr), .ED_54M_ONLY_O(m54),
        .PORT_SWAP_O(swp), .DDR_EDGE_O(edge_sel), .BLACK_BAR_ED_O(bbe),
        .BLACK_BAR_SD_O(bbs), .CSC_MANUAL_O(csc), .SYNC_ON_RGB_O(sor),
        .YPRPB_SEL_O(ypr), .S_HSYNC_O(sh), .S_VSYNC_O(sv),
        .GREEN_LUMA_COEF_O(gl), .GREEN_BLUE_DIFF_COEF_O(gu),
        .GREEN_RED_DIFF_COEF_O(gv), .BLUE_FROM_DIFF_COEF_O(bu),
        .RED_FROM_DIFF_COEF_O(rv));

    vomc_host_model host (
        .clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
        .rdata_i(rdata));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Derived outputs land one edge after the register does
    task automatic settle;
        host.idle();
        @(posedge clk);
        @(negedge clk);
    endtask

    // Async assert, release on a falling edge away from sampling
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
    endtask

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Bound on the whole run, a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial
    begin
        {ed_tp, sd_tp, sd_h, sd_v, ed_h, ed_v} = 6'h00;
        n_errors = 0;
        samples_checked = 0;
        do_reset();
        @(posedge clk);
        @(negedge clk);
        chk_out(16'(flags), 16'h2004);
        chk_out(16'(gl), 16'h013b);
        // Reset contents of every register
        for (int i = 0; i < 9; i++)
        begin
            host.rd_reg(8'(i + 1), rd);
            chk_reg(rd, rst_val[i]);
        end
        // Row table: modes, swap, edges, output mode bits, syncs
        foreach (rows[i])
        begin
            @(negedge clk);
            {ed_tp, sd_tp} = rows[i].tp;
            {sd_h, sd_v, ed_h, ed_v} = rows[i].syn;
            host.wr_reg(8'h01, rows[i].m01);
            host.wr_reg(8'h02, rows[i].m02);
            settle();
            chk_out(16'(flags), 16'(rows[i].exp));
        end
        // Back-to-back coefficient writes, then joined values
        host.wr_reg(8'h03, 8'h02);
        host.wr_reg(8'h04, 8'h1b);
        for (int i = 0; i < 5; i++)
            host.wr_reg(8'(8'h05 + i), 8'(8'h81 + i));
        settle();
        chk_out(16'(gl), 16'({8'h81, 2'b10}));
        chk_out(16'(gu), 16'({8'h82, 2'b00}));
        chk_out(16'(gv), 16'({8'h83, 2'b01}));
        chk_out(16'(bu), 16'({8'h84, 2'b10}));
        chk_out(16'(rv), 16'({8'h85, 2'b11}));
        // Write then read at once, then an unmapped address
        host.wr_reg(8'h02, 8'h48);
        host.rd_reg(8'h02, rd);
        chk_reg(rd, 8'h48);
        host.wr_reg(8'h3f, 8'h5a);
        host.rd_reg(8'h3f, rd);
        chk_reg(rd, 8'h00);
        // Reserved bits of the mode select register stay zero
        host.wr_reg(8'h01, 8'hff);
        host.rd_reg(8'h01, rd);
        chk_reg(rd, `VOMC_WMASK_MODE_SELECT);
        // Second reset in mid-run clears outputs, restores registers
        @(negedge clk);
        rst_n = 1'b0;
        #1;
        chk_out(16'(flags), 16'h0000);
        chk_out(16'(gl), 16'h0000);
        chk_reg(rdata, 8'h00);
        do_reset();
        host.rd_reg(8'h02, rd);
        chk_reg(rd, `VOMC_RST_OUT_MODE);
        chk_out(16'(flags), 16'h2004);
        tally_and_finish();
    end
endmodule // tb_video_output_mode_csc_config

`default_nettype wire
